/* shared/split_pwm_defs.vh */
// Constants for the dual channel split pulse width modulator
// Assumes a plain register port with one-cycle strobes
`ifndef SPLIT_PWM_DEFS_VH
`define SPLIT_PWM_DEFS_VH

`define ADDR_DUTY0      4'h0
`define ADDR_DUTY1      4'h1
`define ADDR_PORTDIR    4'h2
`define ADDR_PORTLATCH  4'h3
`define ADDR_MODECFG    4'h4
`define ADDR_PADSTATE   4'h5
`define ADDR_STATUS     4'h6

`define DUTY_RESET      8'h00
`define PORTDIR_RESET   2'h3
`define PORTLATCH_RESET 2'h0
`define MODE_RESET      1'h0

`define MODE_62         1'h0
`define MODE_71         1'h1

`define CYCLE_LAST      8'hff

`endif

/* rtl/pwm_channel.v */
// One modulator channel: computes the waveform from the count and duty
// Assumes count and mode come from the same clock domain
`timescale 1ns/1ns
`include "split_pwm_defs.vh"

module pwm_channel (
    // Clock and reset
    input  wire       mclk,
    input  wire       rstn,
    // Control
    input  wire       modeSel,
    input  wire [7:0] cycleCount,
    input  wire [7:0] dutyLive,
    // Waveform
    output reg        wave
);

    reg        next_wave;
    reg  [6:0] coarseDuty;
    reg  [1:0] fineSpreadCount;
    reg  [1:0] subIndex;
    reg  [6:0] subCount;
    reg  [7:0] highLen;

    always @* begin
        if (modeSel == `MODE_62) begin
            // RL6 bit split 6+2
            coarseDuty      = {1'b0, dutyLive[7:2]};
            fineSpreadCount = dutyLive[1:0];
            // RL5 four 64-clock sub-cycles
            subIndex        = cycleCount[7:6];
            subCount        = {1'b0, cycleCount[5:0]};
        end else begin
            // RL9 bit split 7+1
            coarseDuty      = dutyLive[7:1];
            fineSpreadCount = {1'b0, dutyLive[0]};
            // RL8 two 128-clock sub-cycles
            subIndex        = {1'b0, cycleCount[7]};
            subCount        = cycleCount[6:0];
        end
        // RL7 RL10 extra clock when index below fine count
        if (subIndex < fineSpreadCount)
            highLen = {1'b0, coarseDuty} + 8'h01;
        else
            highLen = {1'b0, coarseDuty};
        // RL17 high from start of sub-cycle
        next_wave = ({1'b0, subCount} < highLen);
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

endmodule // pwm_channel

/* rtl/dual_channel_split_pwm.v */
// Dual channel 8-bit split pulse width modulator with Port A pin gating
// Assumes one 10 MHz clock, a plain register port and external pad logic
//
// Notes on behaviour
// RL1 - Two independent channels, each with its own 8-bit duty register.
// RL2 - One mode option picks 6+2 or 7+1 for both channels.
// RL3 - Counter advances each system clock; full cycle is 256 clocks.
// RL4 - Hardware divides sub-cycles; software only writes duty and mode.
// RL5 - In 6+2 mode four sub-cycles of 64 clocks each.
// RL6 - In 6+2 mode bits 7..2 coarse, bits 1..0 fine.
// RL7 - 6+2: sub-cycle high coarse+1 when index below fine, else coarse.
// RL8 - In 7+1 mode two sub-cycles of 128 clocks each.
// RL9 - In 7+1 mode bits 7..1 coarse, bit 0 fine.
// RL10 - 7+1: sub-cycle high coarse+1 when index below fine, else coarse.
// RL11 - Channel 0 drives port line 0, channel 1 drives line 1.
// RL12 - Software clears direction bit to make pin an output.
// RL13 - Software loads duty before enabling output via latch bit.
// RL14 - Latch bit 1 with output direction passes waveform to pin.
// RL15 - Latch bit 0 forces the pin low.
// RL16 - Direction bit 1 makes the pin a plain input, no waveform.
// RL17 - Output high from sub-cycle start for computed clocks, then low.
// RL18 - New duty value takes effect at the next full cycle start.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "split_pwm_defs.vh"

module dual_channel_split_pwm (
    // Clock and reset
    input  wire       mclk,
    input  wire       rstn,
    // Register port
    input  wire [3:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    // Port A lines 0 and 1
    input  wire [1:0] padIn,
    output reg  [1:0] padOut,
    output reg  [1:0] padOe
);

    ////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0] dutyValueCh0;
    reg  [7:0] dutyValueCh1;
    reg  [7:0] dutyLive0;
    reg  [7:0] dutyLive1;
    reg  [1:0] portADirection;
    reg  [1:0] portAOutputLatch;
    reg        modeSel;
    reg  [7:0] cycleCount;
    reg  [1:0] padSync1;
    reg  [1:0] padSync2;
    reg  [7:0] next_rdata;
    reg  [1:0] next_padOut;
    reg  [1:0] next_padOe;
    wire       wave0;
    wire       wave1;
    wire       cycleEnd;

    assign cycleEnd = (cycleCount == `CYCLE_LAST);

    always @(posedge mclk) begin
        if (!rstn) begin
            dutyValueCh0     <= `DUTY_RESET;
            dutyValueCh1     <= `DUTY_RESET;
            portADirection   <= `PORTDIR_RESET;
            portAOutputLatch <= `PORTLATCH_RESET;
            modeSel          <= `MODE_RESET;
        end else if (regWrite) begin
            case (regAddr)
                // RL1 duty registers per channel
                `ADDR_DUTY0:     dutyValueCh0     <= regWdata;
                `ADDR_DUTY1:     dutyValueCh1     <= regWdata;
                `ADDR_PORTDIR:   portADirection   <= regWdata[1:0];
                `ADDR_PORTLATCH: portAOutputLatch <= regWdata[1:0];
                // RL2 one mode for both channels
                `ADDR_MODECFG:   modeSel          <= regWdata[0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Cycle counter and duty take-over

    always @(posedge mclk) begin
        if (!rstn) begin
            cycleCount <= 8'h00;
            dutyLive0  <= `DUTY_RESET;
            dutyLive1  <= `DUTY_RESET;
        end else begin
            // RL3 one count per system clock
            cycleCount <= cycleCount + 8'h01;
            // RL18 duty loads at cycle boundary
            if (cycleEnd) begin
                dutyLive0 <= dutyValueCh0;
                dutyLive1 <= dutyValueCh1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Channels

    // RL4 sub-cycle split done in hardware
    pwm_channel u_ch0 (
        .mclk       (mclk),
        .rstn       (rstn),
        .modeSel    (modeSel),
        .cycleCount (cycleCount),
        .dutyLive   (dutyLive0),
        .wave       (wave0)
    );

    pwm_channel u_ch1 (
        .mclk       (mclk),
        .rstn       (rstn),
        .modeSel    (modeSel),
        .cycleCount (cycleCount),
        .dutyLive   (dutyLive1),
        .wave       (wave1)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin gating

    always @* begin
        // RL11 channel to line mapping
        // RL14 latch bit gates waveform
        // RL15 latch low forces pin low
        next_padOut[0] = portAOutputLatch[0] & wave0;
        next_padOut[1] = portAOutputLatch[1] & wave1;
        // RL16 direction 1 releases the pin
        next_padOe     = ~portADirection;
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            padOut   <= 2'h0;
            padOe    <= 2'h0;
            padSync1 <= 2'h0;
            padSync2 <= 2'h0;
        end else begin
            padOut   <= next_padOut;
            padOe    <= next_padOe;
            padSync1 <= padIn;
            padSync2 <= padSync1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read back

    always @* begin
        case (regAddr)
            `ADDR_DUTY0:     next_rdata = dutyValueCh0;
            `ADDR_DUTY1:     next_rdata = dutyValueCh1;
            `ADDR_PORTDIR:   next_rdata = {6'h00, portADirection};
            `ADDR_PORTLATCH: next_rdata = {6'h00, portAOutputLatch};
            `ADDR_MODECFG:   next_rdata = {7'h00, modeSel};
            // Input lines read the pad, output lines read the latch
            `ADDR_PADSTATE:  next_rdata = {6'h00,
                (portADirection & padSync2) |
                (~portADirection & portAOutputLatch)};
            `ADDR_STATUS:    next_rdata = {4'h0, padOut, wave1, wave0};
            default:         next_rdata = 8'h00;
        endcase
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule // dual_channel_split_pwm

/* testbench/port_load.sv */
// Load on the two shared port lines
// Assumes pull-high resistors on both lines
`timescale 1ns/1ns
module port_load (
    // Drive from the block
    input  wire [1:0] padOut,
    input  wire [1:0] padOe,
    // Resolved pin levels
    output wire [1:0] padIn
);
    assign padIn = (padOut & padOe) | ~padOe;
endmodule // port_load

/* testbench/split_pwm_asserts.sv */
// Port checker for the split modulator
// Assumes bind to the top module
`timescale 1ns/1ns
module split_pwm_asserts (
    // Watched ports
    input wire       mclk,
    input wire       rstn,
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdata,
    input wire [1:0] padOut,
    input wire [1:0] padOe
);
    reg [1:0] latchSh;
    reg [1:0] dirSh;
    reg [8:0] runLen;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    always @(posedge mclk) begin
        if (!rstn) begin
            latchSh <= 2'h0;
            dirSh   <= 2'h3;
            runLen  <= 9'h000;
        end else begin
            if (regWrite && regAddr == 4'h3) latchSh <= regWdata[1:0];
            if (regWrite && regAddr == 4'h2) dirSh <= regWdata[1:0];
            runLen <= padOut[0] ? runLen + 9'h001 : 9'h000;
        end
    end
    ////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (
        !$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not zero");
    duty_readback_a: assert property (regWrite && regAddr == 4'h0 ##1
        regRead && regAddr == 4'h0 |=> regRdata == $past(regWdata, 2))
        else $error("duty readback wrong");
    mode_readback_a: assert property (regWrite && regAddr == 4'h4 ##1
        regRead && regAddr == 4'h4 |=> regRdata[0] == $past(regWdata[0], 2))
        else $error("mode readback wrong");
    unmapped_zero_a: assert property (regRead && regAddr > 4'h6
        |=> regRdata == 8'h00) else $error("unmapped read not zero");
    dir_enable_a: assert property (padOe == ~$past(dirSh))
        else $error("enable does not follow direction");
    latch_gate_a: assert property (
        (padOut & ~latchSh & ~$past(latchSh)) == 2'h0)
        else $error("pin high with latch off");
    run_bounded_a: assert property (runLen < 9'h100)
        else $error("no low clock within a full cycle");
    reset_quiet_a: assert property (disable iff (1'b0) !rstn
        |=> padOe == 2'h0 && padOut == 2'h0 && regRdata == 8'h00)
        else $error("outputs active in reset");
endmodule // split_pwm_asserts
bind dual_channel_split_pwm split_pwm_asserts split_pwm_asserts_i (
    .mclk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .padOut, .padOe);

/* testbench/dual_channel_split_pwm_tb_top.sv */
// Self-checking bench for the split modulator
// Assumes the pull-high load model on both lines
`timescale 1ns/1ns
`include "split_pwm_defs.vh"
module dual_channel_split_pwm_tb_top;
    typedef struct {logic m; logic [7:0] d0, d1, x0, x1, r;} row_t;
    row_t rows[5] = '{'{1'b0, 8'h05, 8'h64, 8'd2, 8'd25, 8'd4},
        '{1'b0, 8'hba, 8'h81, 8'd47, 8'd33, 8'd4},
        '{1'b1, 8'h65, 8'hc8, 8'd51, 8'd100, 8'd2},
        '{1'b1, 8'h02, 8'hfe, 8'd1, 8'd127, 8'd2},
        '{1'b0, 8'h00, 8'h00, 8'd0, 8'd0, 8'd0}};
    logic mclk = 0, rstn = 0, regWrite = 0, regRead = 0;
    logic [3:0] regAddr = 0;
    logic [7:0] regWdata = 0, regRdata;
    logic [1:0] padIn, padOut, padOe, pv;
    int nMismatch = 0, samplesChecked = 0, tot[2], mx[2], rs[2], rn[2];
    always #50 mclk = ~mclk;
    dual_channel_split_pwm dual_channel_split_pwm_i (.mclk(mclk),
        .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .padIn(padIn), .padOut(padOut), .padOe(padOe));
    port_load port_load_i (.padOut(padOut), .padOe(padOe), .padIn(padIn));
    task chk(input logic [15:0] s, input logic [15:0] e);
        samplesChecked++;
        if (s !== e) begin
            nMismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        regWrite <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk) regWrite <= 0;
        @(posedge mclk);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        regRead <= 1;
        regAddr <= a;
        @(posedge mclk) regRead <= 0;
        @(posedge mclk) chk(regRdata, e);
    endtask
    // Write, then read back at once
    task wrrd(input logic [3:0] a, input logic [7:0] d);
        regWrite <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk) regWrite <= 0;
        regRead <= 1;
        @(posedge mclk) regRead <= 0;
        @(posedge mclk) chk(regRdata, d);
    endtask
    task meas;
        pv = padOut;
        for (int c = 0; c < 2; c++) begin
            tot[c] = 0; mx[c] = 0; rs[c] = 0; rn[c] = 0;
        end
        for (int i = 0; i < 512; i++) begin
            @(posedge mclk);
            for (int c = 0; c < 2; c++) begin
                rn[c] = padOut[c] ? rn[c] + 1 : 0;
                if (rn[c] > mx[c]) mx[c] = rn[c];
                if (i < 256 && padOut[c]) tot[c]++;
                if (i < 256 && padOut[c] && !pv[c]) rs[c]++;
            end
            pv = padOut;
        end
    endtask
    task final_report;
        $display("checked=%0d mismatches=%0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #1200000;
        nMismatch++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1;
        @(posedge mclk);
        rd(`ADDR_PORTDIR, 8'h03);
        rd(`ADDR_PORTLATCH, 8'h00);
        rd(`ADDR_DUTY0, 8'h00);
        rd(4'h9, 8'h00);
        for (int k = 0; k < 5; k++) begin
            wrrd(`ADDR_MODECFG, {7'h0, rows[k].m});
            wrrd(`ADDR_DUTY0, rows[k].d0);
            wr(`ADDR_DUTY1, rows[k].d1);
            // output direction, duty first, then latch
            wr(`ADDR_PORTDIR, 8'h00);
            wr(`ADDR_PORTLATCH, 8'h03);
            repeat (300) @(posedge mclk);
            meas;
            chk(16'(tot[0]), rows[k].d0);
            chk(16'(tot[1]), rows[k].d1);
            chk(16'(mx[0]), rows[k].x0);
            chk(16'(mx[1]), rows[k].x1);
            chk(16'(rs[0]), rows[k].r);
            chk(16'(rs[1]), rows[k].r);
        end
        wr(`ADDR_DUTY0, 8'h01);
        repeat (300) @(posedge mclk);
        while (!padOut[0]) @(posedge mclk);
        wr(`ADDR_DUTY0, 8'h80);
        tot[0] = 0;
        repeat (200) begin
            @(posedge mclk);
            if (padOut[0]) tot[0]++;
        end
        chk(16'(tot[0]), 16'h0000);
        repeat (300) @(posedge mclk);
        meas;
        chk(16'(tot[0]), 16'h0080);
        wr(`ADDR_DUTY1, 8'h80);
        wr(`ADDR_PORTLATCH, 8'h01);
        repeat (300) @(posedge mclk);
        meas;
        chk(16'(tot[1]), 16'd0);
        wr(`ADDR_PORTDIR, 8'h02);
        repeat (3) @(posedge mclk);
        chk(padOe, 2'h1);
        rd(`ADDR_PADSTATE, 8'h03);
        // Reset in mid-run
        rstn <= 0;
        repeat (5) @(posedge mclk);
        chk({padOe, padOut}, 4'h0);
        rstn <= 1;
        @(posedge mclk);
        rd(`ADDR_PORTDIR, 8'h03);
        rd(`ADDR_DUTY0, 8'h00);
        final_report;
    end
endmodule // dual_channel_split_pwm_tb_top
